// ==== emb_defines.vh ====
// Summary of operation
// - data path is 8 or 16 bits, chosen by a run-time control field
// - four regions, each with its own active-low select output
// - each region has separate read and write wait-state counts
// - static async reads and writes; page mode only on the non-multiplexed bus
// - address latch marks the address phase in muxed modes, polarity selectable
// - 16-bit muxed: address/data share two low ports, high address on third
// - 16-bit mode: separate low and high write strobes, one read strobe
// - 8-bit muxed: 24 address bits, low data byte shares port with low address
// - 8-bit muxed: second port carries mid address, then zeros on write
// - 8-bit muxed: third port drives top address byte directly
// - 8-bit muxed: low write strobe is the only write strobe, read strobe reads
// - 8-bit non-muxed: data on one port, 16 address bits held on two ports
// - synchronous burst reads and writes in muxed and non-muxed modes
// - burst clock output runs full or half rate and can be disabled
// - memory holds wait input low while not ready; a burst beat is stretched
// - active-low burst advance output enables burst and advances memory address
// - byte enables share pins with write strobes, chosen by a control bit
// - burst length, type and read/write timing are programmable
`ifndef EMB_DEFINES_VH
`define EMB_DEFINES_VH
`define EMB_CTRL_OFF     12'h000
`define EMB_STAT_OFF     12'h004
`define EMB_REG0_OFF     12'h010
`define EMB_REG1_OFF     12'h014
`define EMB_REG2_OFF     12'h018
`define EMB_REG3_OFF     12'h01C
`define EMB_CTRL_RST     32'h0000_0000
`define EMB_REGN_RST     32'h0000_00FF
`define EMB_MODE_8NM     2'h0
`define EMB_MODE_8MX     2'h1
`define EMB_MODE_16MX    2'h2
`define EMB_C_MODE       1:0
`define EMB_C_ALEPOL     2
`define EMB_C_BEFN       3
`define EMB_C_BURST      4
`define EMB_C_BCLKEN     5
`define EMB_C_BCLKHALF   6
`define EMB_R_RWAIT      3:0
`define EMB_R_WWAIT      7:4
`define EMB_R_BASE       15:8
`define EMB_R_MASK       23:16
`define EMB_R_PAGE       24
`define EMB_R_BLEN       27:25
`define EMB_R_BWRAP      28
`define EMB_R_BEN        29
`define EMB_S_ERR        3
`define EMB_BEAT_GAP     2'h2
`endif

// ==== emb_ctrl.v ====
`timescale 1ns/1ps
`include "emb_defines.vh"
module emb_ctrl (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [23:0] req_addr,
  input  wire [15:0] req_wdata,
  input  wire [1:0]  req_be,
  output reg         req_done,
  output reg         req_err,
  output reg  [15:0] req_rdata,
  output wire [7:0]  p7_o,
  output wire [7:0]  p8_o,
  output wire        p8_oe,
  input  wire [7:0]  p8_i,
  output wire [7:0]  p9_o,
  output wire        p9_oe,
  input  wire [7:0]  p9_i,
  output wire        read_strobe_n,
  output wire        write_low_strobe_n,
  output wire        write_high_strobe_n,
  output wire        addr_latch_out,
  output wire        region0_select_n,
  output wire        region1_select_n,
  output wire        region2_select_n,
  output wire        region3_select_n,
  output wire        burst_bus_clock_out,
  input  wire        not_ready_in_n,
  output wire        burst_advance_n,
  output wire        write_enable_out_n
);
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_ALE   = 6'h02;
  localparam [5:0] S_HOLD  = 6'h04;
  localparam [5:0] S_STRB  = 6'h08;
  localparam [5:0] S_BURST = 6'h10;
  localparam [5:0] S_RECOV = 6'h20;

  reg  [31:0] ctrl_q;
  reg  [31:0] rcfg_q [0:3];
  reg  [5:0]  st_q;
  reg  [23:0] addr_q;
  reg  [15:0] dout_q;
  reg         wr_q;
  reg  [1:0]  be_q;
  reg  [1:0]  rgn_q;
  reg         ok_q;
  reg         cs_hold_q;
  reg         burst_q;
  reg  [3:0]  wcnt_q;
  reg  [2:0]  beat_q;
  reg  [1:0]  gap_q;
  reg         err_q;
  reg         waited_q;
  reg  [7:0]  p8_m_q;
  reg  [7:0]  p8_s_q;
  reg  [7:0]  p9_m_q;
  reg  [7:0]  p9_s_q;
  reg         rdy_m_q;
  reg         rdy_s_q;
  reg         div_q;
  reg         bclk_gate_q;
  reg  [1:0]  hit_idx;
  reg         hit_any;
  integer     i;

  wire [1:0] mode     = ctrl_q[`EMB_C_MODE];
  wire       mode8    = (mode == `EMB_MODE_8NM) || (mode == `EMB_MODE_8MX);
  wire       muxed    = (mode != `EMB_MODE_8NM);
  wire       apb_wr   = psel & penable & pwrite;
  wire       mapped   = (paddr == `EMB_CTRL_OFF) || (paddr == `EMB_STAT_OFF) ||
                        (paddr == `EMB_REG0_OFF) || (paddr == `EMB_REG1_OFF) ||
                        (paddr == `EMB_REG2_OFF) || (paddr == `EMB_REG3_OFF);
  wire [31:0] cur_cfg = rcfg_q[rgn_q];
  wire       tick     = ctrl_q[`EMB_C_BCLKHALF] ? ~div_q : 1'b1;
  wire       beat     = st_q[2'd0+4] & tick & (wcnt_q == 4'h0) & (gap_q == 2'h0) & rdy_s_q;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  function region_hit;
    input [23:0] a;
    input [31:0] cfg;
    begin
      region_hit = ((a[23:16] ^ cfg[`EMB_R_BASE]) & cfg[`EMB_R_MASK]) == 8'h00;
    end
  endfunction

  // lowest index wins so one select at most is ever active
  always @* begin
    hit_idx = 2'h0;
    hit_any = 1'b0;
    for (i = 3; i >= 0; i = i - 1) begin
      if (region_hit(req_addr, rcfg_q[i])) begin
        hit_idx = i[1:0];
        hit_any = 1'b1;
      end
    end
  end

  // page reuse needs the same region and the same 8-byte page, non-muxed only
  wire page_hit = cs_hold_q && hit_any && (hit_idx == rgn_q) &&
                  (req_addr[23:3] == addr_q[23:3]) && (req_write == wr_q);

  always @* begin
    case (paddr)
      `EMB_CTRL_OFF: prdata = ctrl_q;
      `EMB_STAT_OFF: prdata = {27'h0, waited_q, err_q, rgn_q, ~st_q[0]};
      `EMB_REG0_OFF: prdata = rcfg_q[0];
      `EMB_REG1_OFF: prdata = rcfg_q[1];
      `EMB_REG2_OFF: prdata = rcfg_q[2];
      `EMB_REG3_OFF: prdata = rcfg_q[3];
      default:       prdata = 32'h0000_0000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= `EMB_CTRL_RST;
      rcfg_q[0] <= `EMB_REGN_RST;
      rcfg_q[1] <= `EMB_REGN_RST;
      rcfg_q[2] <= `EMB_REGN_RST;
      rcfg_q[3] <= `EMB_REGN_RST;
    end else if (apb_wr) begin
      case (paddr)
        `EMB_CTRL_OFF: ctrl_q    <= {25'h0, pwdata[6:0]};
        `EMB_REG0_OFF: rcfg_q[0] <= {2'h0, pwdata[29:0]};
        `EMB_REG1_OFF: rcfg_q[1] <= {2'h0, pwdata[29:0]};
        `EMB_REG2_OFF: rcfg_q[2] <= {2'h0, pwdata[29:0]};
        `EMB_REG3_OFF: rcfg_q[3] <= {2'h0, pwdata[29:0]};
        default: ;
      endcase
    end
  end

  // pins from the outside world pass two stages before use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p8_m_q  <= 8'h00;
      p8_s_q  <= 8'h00;
      p9_m_q  <= 8'h00;
      p9_s_q  <= 8'h00;
      rdy_m_q <= 1'b1;
      rdy_s_q <= 1'b1;
    end else begin
      p8_m_q  <= p8_i;
      p8_s_q  <= p8_m_q;
      p9_m_q  <= p9_i;
      p9_s_q  <= p9_m_q;
      rdy_m_q <= not_ready_in_n;
      rdy_s_q <= rdy_m_q;
    end
  end

  // burst clock: pclk itself at full rate, a divider at half rate
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 1'b0;
    end else begin
      div_q <= ~div_q;
    end
  end

  // gate updated on the falling edge so the full-rate output cannot glitch
  always @(negedge pclk or negedge presetn) begin
    if (!presetn) begin
      bclk_gate_q <= 1'b0;
    end else begin
      bclk_gate_q <= ctrl_q[`EMB_C_BCLKEN];
    end
  end

  assign burst_bus_clock_out = ctrl_q[`EMB_C_BCLKHALF] ? (div_q & ctrl_q[`EMB_C_BCLKEN]) :
                               (pclk & bclk_gate_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= S_IDLE;
      addr_q    <= 24'h00_0000;
      dout_q    <= 16'h0000;
      wr_q      <= 1'b0;
      be_q      <= 2'h0;
      rgn_q     <= 2'h0;
      ok_q      <= 1'b0;
      cs_hold_q <= 1'b0;
      burst_q   <= 1'b0;
      wcnt_q    <= 4'h0;
      beat_q    <= 3'h0;
      gap_q     <= 2'h0;
      err_q     <= 1'b0;
      waited_q  <= 1'b0;
      req_done  <= 1'b0;
      req_err   <= 1'b0;
      req_rdata <= 16'h0000;
    end else begin
      req_done <= 1'b0;
      req_err  <= 1'b0;
      // software clears by writing one; a new error in that cycle wins
      if (apb_wr && (paddr == `EMB_STAT_OFF) && pwdata[`EMB_S_ERR])
        err_q <= 1'b0;
      if (gap_q != 2'h0)
        gap_q <= gap_q - 2'h1;
      case (st_q)
        S_IDLE: begin
          if (req_valid) begin
            if (!hit_any) begin
              err_q     <= 1'b1;
              req_done  <= 1'b1;
              req_err   <= 1'b1;
              ok_q      <= 1'b0;
              cs_hold_q <= 1'b0;
              st_q      <= S_RECOV;
            end else begin
              addr_q   <= req_addr;
              wr_q     <= req_write;
              be_q     <= mode8 ? 2'h1 : req_be;
              dout_q   <= mode8 ? {8'h00, req_wdata[7:0]} : req_wdata;
              rgn_q    <= hit_idx;
              ok_q     <= 1'b1;
              burst_q  <= ctrl_q[`EMB_C_BURST] & rcfg_q[hit_idx][`EMB_R_BEN];
              beat_q   <= 3'h0;
              wcnt_q   <= req_write ? rcfg_q[hit_idx][`EMB_R_WWAIT] :
                                      rcfg_q[hit_idx][`EMB_R_RWAIT];
              if (page_hit)
                st_q <= S_STRB;
              else
                st_q <= S_ALE;
              if (!page_hit)
                cs_hold_q <= 1'b0;
            end
          end
        end
        S_ALE: begin
          // muxed: hold address one more cycle with the latch inactive
          if (muxed)
            st_q <= S_HOLD;
          else if (burst_q)
            st_q <= S_BURST;
          else
            st_q <= S_STRB;
        end
        S_HOLD: begin
          st_q <= burst_q ? S_BURST : S_STRB;
        end
        S_STRB: begin
          if (wcnt_q != 4'h0) begin
            wcnt_q <= wcnt_q - 4'h1;
          end else begin
            // read data lags the pins by two cycles; wait states must cover it
            req_rdata <= mode8 ? {8'h00, p8_s_q} : {p9_s_q, p8_s_q};
            req_done  <= 1'b1;
            cs_hold_q <= ~muxed & cur_cfg[`EMB_R_PAGE] & ~burst_q;
            st_q      <= S_RECOV;
          end
        end
        S_BURST: begin
          if (tick && !rdy_s_q)
            waited_q <= 1'b1;
          if (wr_q && (gap_q != 2'h0))
            dout_q <= mode8 ? {8'h00, req_wdata[7:0]} : req_wdata;
          if (tick && (wcnt_q != 4'h0))
            wcnt_q <= wcnt_q - 4'h1;
          if (beat) begin
            req_rdata <= mode8 ? {8'h00, p8_s_q} : {p9_s_q, p8_s_q};
            req_done  <= 1'b1;
            gap_q     <= `EMB_BEAT_GAP;
            beat_q    <= beat_q + 3'h1;
            if (cur_cfg[`EMB_R_BWRAP])
              addr_q[2:0] <= addr_q[2:0] + 3'h1;
            else
              addr_q <= addr_q + 24'h00_0001;
            if (beat_q == cur_cfg[`EMB_R_BLEN])
              st_q <= S_RECOV;
          end
        end
        S_RECOV: begin
          ok_q <= cs_hold_q;
          st_q <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // strobes decode from state flops; all change on the same clock edge
  wire in_addr  = st_q[1] | st_q[2];
  wire in_strb  = st_q[3];
  wire in_burst = st_q[4];
  wire active   = ok_q & ~st_q[0] & ~st_q[5] | cs_hold_q;
  wire data_ph  = in_strb | in_burst;
  wire wrl_n    = ~(in_strb & wr_q & be_q[0]);
  wire wrh_n    = ~(in_strb & wr_q & ~mode8 & be_q[1]);
  wire lbe_n    = ~(active & be_q[0]);
  wire ube_n    = ~(active & ~mode8 & be_q[1]);
  wire ale_act  = st_q[1] & muxed & ok_q;

  assign read_strobe_n       = ~(data_ph & ~wr_q);
  assign write_low_strobe_n  = ctrl_q[`EMB_C_BEFN] ? lbe_n : wrl_n;
  assign write_high_strobe_n = ctrl_q[`EMB_C_BEFN] ? ube_n : wrh_n;
  assign addr_latch_out      = ctrl_q[`EMB_C_ALEPOL] ? ale_act : ~ale_act;
  assign write_enable_out_n  = ~(in_burst & wr_q);
  assign burst_advance_n     = ~(burst_q & ok_q & (in_addr | in_burst));

  assign region0_select_n = ~(active & (rgn_q == 2'h0));
  assign region1_select_n = ~(active & (rgn_q == 2'h1));
  assign region2_select_n = ~(active & (rgn_q == 2'h2));
  assign region3_select_n = ~(active & (rgn_q == 2'h3));

  // port 7: top address byte when muxed, bits 15:8 when non-muxed
  assign p7_o = muxed ? addr_q[23:16] : addr_q[15:8];

  // port 8: low address during address phase when muxed, data otherwise
  assign p8_o  = (muxed & in_addr) ? addr_q[7:0] : dout_q[7:0];
  assign p8_oe = ok_q & ((muxed & in_addr) | (data_ph & wr_q));

  // port 9: mid address when muxed, then high data byte (zeros on 8-bit write), low address non-muxed
  assign p9_o  = ~muxed ? addr_q[7:0] :
                 in_addr ? addr_q[15:8] :
                 mode8 ? 8'h00 : dout_q[15:8];
  assign p9_oe = ok_q & (~muxed & active | muxed & (in_addr | (data_ph & wr_q)));
endmodule

// ==== emb_ctrl_asserts.sv ====
`timescale 1ns/1ps
module emb_ctrl_chk (
  input wire       pclk,
  input wire       presetn,
  input wire       req_done,
  input wire       req_err,
  input wire [7:0] p8_o,
  input wire       p8_oe,
  input wire       read_strobe_n,
  input wire       write_low_strobe_n,
  input wire       write_high_strobe_n,
  input wire       addr_latch_out,
  input wire       region0_select_n,
  input wire       region1_select_n,
  input wire       region2_select_n,
  input wire       region3_select_n
);
  wire [3:0] sel_n = {region3_select_n, region2_select_n, region1_select_n, region0_select_n};
  wire       strb  = !read_strobe_n || !write_low_strobe_n;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_region: assert property ($onehot0(~sel_n))
    else $error("two region selects low");
  a_err_done: assert property (req_err |-> req_done)
    else $error("decode error without done");
  a_done_single: assert property (req_done |=> !req_done)
    else $error("done longer than one cycle");
  a_strobe_excl: assert property (!read_strobe_n |-> write_low_strobe_n && write_high_strobe_n)
    else $error("read and write strobes together");
  a_strobe_select: assert property (strb |-> sel_n != 4'hF)
    else $error("strobe without region select");
  a_read_released: assert property (!read_strobe_n |-> !p8_oe)
    else $error("data port driven during read");
  a_wdata_steady: assert property (!write_low_strobe_n && $past(!write_low_strobe_n) |-> $stable(p8_o))
    else $error("write data moved under strobe");
  a_latch_quiet: assert property (strb && $past(strb) |-> $stable(addr_latch_out))
    else $error("address latch moved under strobe");
  a_done_bound: assert property ($rose(sel_n != 4'hF) |-> ##[1:64] req_done)
    else $error("access never finished");
endmodule
bind emb_ctrl emb_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .req_done(req_done), .req_err(req_err),
  .p8_o(p8_o), .p8_oe(p8_oe), .read_strobe_n(read_strobe_n), .write_low_strobe_n(write_low_strobe_n),
  .write_high_strobe_n(write_high_strobe_n), .addr_latch_out(addr_latch_out),
  .region0_select_n(region0_select_n), .region1_select_n(region1_select_n),
  .region2_select_n(region2_select_n), .region3_select_n(region3_select_n));

// ==== emb_mem_model.sv ====
`timescale 1ns/1ps
module emb_mem_model (
  input  wire       pclk,
  input  wire [1:0] mode,
  input  wire       ale_pol,
  input  wire       addr_latch_out,
  input  wire [7:0] p8_o,
  input  wire [7:0] p9_o,
  input  wire       read_strobe_n,
  input  wire       write_low_strobe_n,
  input  wire       write_high_strobe_n,
  output wire [7:0] drv8,
  output wire [7:0] drv9,
  output wire       not_ready_in_n
);
  logic [7:0] lo [0:255];
  logic [7:0] hi [0:255];
  logic [7:0] key_q = 8'h00;
  wire        mux = mode != 2'h0;
  wire  [7:0] key = mux ? key_q : p9_o;
  always @(posedge pclk) begin
    if (mux && addr_latch_out == ale_pol) key_q <= p8_o;
    if (!write_low_strobe_n) lo[key] <= p8_o;
    if (!write_high_strobe_n && mode[1]) hi[key] <= p9_o;
  end
  // released lines show the inverse so a stale value never reads back as good
  assign drv8 = !read_strobe_n ? lo[key] : ~lo[key];
  assign drv9 = !read_strobe_n && mode[1] ? hi[key] : ~hi[key];
  assign not_ready_in_n = 1'b1;
endmodule

// ==== tb_external_memory_bus_ctrl.sv ====
`timescale 1ns/1ps
`include "emb_defines.vh"
module tb_external_memory_bus_ctrl;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic        req_valid = 0, req_write = 0, req_done, req_err;
  logic [23:0] req_addr = 0;
  logic [15:0] req_wdata = 0, req_rdata;
  logic [1:0]  req_be = 0, mode = 0;
  logic [7:0]  p7_o, p8_o, p9_o, p8_i, p9_i, drv8, drv9, s_p7, s_p9;
  logic        p8_oe, p9_oe, read_strobe_n, write_low_strobe_n, write_high_strobe_n, addr_latch_out;
  logic        region0_select_n, region1_select_n, region2_select_n, region3_select_n;
  logic        burst_bus_clock_out, not_ready_in_n, burst_advance_n, write_enable_out_n, pol = 0, s_wh;
  logic [3:0]  s_sel;
  int          fail_count = 0, n_tests = 0, bclk_n = 0;
  emb_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .req_valid, .req_write, .req_addr, .req_wdata, .req_be, .req_done, .req_err, .req_rdata, .p7_o,
    .p8_o, .p8_oe, .p8_i, .p9_o, .p9_oe, .p9_i, .read_strobe_n, .write_low_strobe_n, .write_high_strobe_n,
    .addr_latch_out, .region0_select_n, .region1_select_n, .region2_select_n, .region3_select_n,
    .burst_bus_clock_out, .not_ready_in_n, .burst_advance_n, .write_enable_out_n);
  emb_mem_model mem (.pclk, .mode, .ale_pol(pol), .addr_latch_out, .p8_o, .p9_o, .read_strobe_n,
    .write_low_strobe_n, .write_high_strobe_n, .drv8, .drv9, .not_ready_in_n);
  assign p8_i = p8_oe ? p8_o : drv8;
  assign p9_i = p9_oe ? p9_o : drv9;
  always #10 pclk = ~pclk;
  always @(posedge burst_bus_clock_out) bclk_n++;
  always @(posedge pclk) if (!write_low_strobe_n || !read_strobe_n) begin
    s_p7 <= p7_o;
    s_p9 <= p9_o;
    s_wh <= write_high_strobe_n;
    s_sel <= {region3_select_n, region2_select_n, region1_select_n, region0_select_n};
  end
  task report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge pclk) begin psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; end
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task ext(input logic w, input logic [23:0] a, input logic [15:0] d, input logic [1:0] be,
           output int n, output logic e);
    @(posedge pclk) begin req_valid <= 1; req_write <= w; req_addr <= a; req_wdata <= d; req_be <= be; end
    n = 0;
    forever begin @(posedge pclk); #1; if (req_done === 1'b1) break; n++; end
    e = req_err;
    @(posedge pclk) req_valid <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task t_regs;
    logic [31:0] r;
    logic        e;
    apb(0, `EMB_CTRL_OFF, 0, r, e); chk(r, `EMB_CTRL_RST);
    apb(0, `EMB_REG2_OFF, 0, r, e); chk(r, `EMB_REGN_RST);
    apb(0, 12'h0FC, 0, r, e); chk({r[30:0], e}, 32'h1);
    for (int i = 0; i < 4; i++) apb(1, `EMB_REG0_OFF + 12'(4 * i), {16'h00FF, 8'(i), 4'(3 - i), 4'(2 + i)}, r, e);
    apb(0, `EMB_REG1_OFF, 0, r, e); chk(r, 32'h00FF0123);
  endtask
  task t_mux16;
    int n;
    logic e;
    logic [31:0] r;
    mode = 2'h2; pol = 1;
    apb(1, `EMB_CTRL_OFF, 32'h6, r, e);
    ext(1, 24'h000012, 16'hA5C3, 2'h3, n, e); chk(n, 6);
    chk(addr_latch_out, 1'b0);
    ext(1, 24'h000012, 16'h1177, 2'h1, n, e); chk(s_wh, 1'b1);
    for (int i = 0; i < 4; i++) begin
      ext(0, {8'(i), 16'h0012}, 0, 2'h3, n, e); chk(n, 5 + i);
      chk(req_rdata, 16'hA577);
      chk(s_sel, 4'hF ^ (4'h1 << i));
    end
  endtask
  task t_mux8;
    int n;
    logic e;
    logic [31:0] r;
    mode = 2'h1; pol = 0;
    apb(1, `EMB_CTRL_OFF, 32'h1, r, e);
    ext(1, 24'h030055, 16'h0066, 2'h1, n, e); chk(n, 3);
    chk(s_p9, 8'h00);
    chk(s_p7, 8'h03);
    chk(s_wh, 1'b1);
    chk(addr_latch_out, 1'b1);
    ext(0, 24'h030055, 0, 2'h1, n, e); chk(req_rdata, 16'h0066);
  endtask
  task t_nm8;
    int n;
    logic e;
    logic [31:0] r;
    mode = 2'h0;
    apb(1, `EMB_CTRL_OFF, 32'h0, r, e);
    ext(1, 24'h003C77, 16'h0099, 2'h1, n, e); chk(n, 5);
    chk({s_p7, s_p9}, 16'h3C77);
    ext(0, 24'h003C77, 0, 2'h1, n, e); chk(n, 4);
    chk(req_rdata, 16'h0099);
    ext(0, 24'h800000, 0, 2'h1, n, e);
    chk({n[7:0], e}, 9'h001);
  endtask
  // two-beat burst read on the non-muxed bus; valid held across both beats
  task t_burst;
    int n;
    logic e;
    logic [31:0] r;
    ext(1, 24'h003C76, 16'h0055, 2'h1, n, e);
    apb(1, `EMB_REG0_OFF, 32'h22FF_0032, r, e);
    apb(1, `EMB_CTRL_OFF, 32'h10, r, e);
    @(posedge pclk) begin
      req_valid <= 1;
      req_write <= 0;
      req_addr  <= 24'h003C76;
    end
    for (int k = 0; k < 2; k++) begin
      do begin
        @(posedge pclk);
        #1;
      end while (req_done !== 1'b1);
      chk(req_rdata, k == 0 ? 32'h55 : 32'h99);
      if (k == 0)
        chk({burst_advance_n, write_enable_out_n}, 2'b01);
    end
    @(posedge pclk) req_valid <= 0;
    repeat (2) @(posedge pclk);
    apb(0, `EMB_STAT_OFF, 0, r, e);
    chk(r, 32'h8);
    apb(1, `EMB_STAT_OFF, 32'h8, r, e);
    apb(0, `EMB_STAT_OFF, 0, r, e);
    chk(r, 32'h0);
  endtask
  task t_bclk;
    int b;
    logic e;
    logic [31:0] r;
    for (int k = 0; k < 3; k++) begin
      apb(1, `EMB_CTRL_OFF, k == 0 ? 32'h0 : k == 1 ? 32'h20 : 32'h60, r, e);
      #1 b = bclk_n;
      repeat (20) @(posedge pclk);
      #1 chk(bclk_n - b, k == 0 ? 0 : k == 1 ? 20 : 10);
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_regs;
    t_mux16;
    t_mux8;
    t_nm8;
    t_burst;
    t_bclk;
    report_and_stop;
  end
  initial begin
    #500000;
    fail_count++;
    report_and_stop;
  end
endmodule
